// ---- hpsr_top.sv ----
// Overview of operation
// - Swap register bit 0 is upstream, bit 1 port 1, bit 2 port 2, rest reserved.
// - A clear swap bit keeps D+ on the positive pin, a set bit exchanges them.
// - The hub reports its port count and also drives a logical number for each physical port.
// - Physical ports are remapped only while the remap enable bit is set.
// - Map bits 7:4 give port 2: 0 off, 1 logical 1, 2 logical 2.
// - Map bits 3:0 give port 1: 0 off, 1 logical 1, 2 logical 2.
// - Map codes 3 to 15 act as code 0 and leave the port disabled.
// - A register reset request restores defaults and self-clears its bit.
`timescale 1ns/1ns
module hpsr_top
	import hpsr_pkg::*;
(
	input  wire logic                       clock,
	input  wire logic                       nrst,
	input  wire logic                       clk_en,
	input  wire logic                       wr_en,
	input  wire logic [hpsr_pkg::ADDR_W-1:0] addr,
	input  wire logic [hpsr_pkg::DATA_W-1:0] wdata,
	output logic      [hpsr_pkg::DATA_W-1:0] rdata,
	input  wire logic                       reg_reset_req,
	output logic                            reg_reset_busy,
	input  wire logic                       logical_remap_enable,
	input  wire logic [2:0]                 dp_func,
	input  wire logic [2:0]                 dm_func,
	output logic      [2:0]                 pos_pin,
	output logic      [2:0]                 neg_pin,
	output logic      [1:0]                 port1_logical,
	output logic      [1:0]                 port2_logical,
	output logic      [1:0]                 port_count
);
	import hpsr_pkg::*;

	logic        rst_s1_q;
	logic        rst_n;
	logic [7:0]  swap_q, swap_d;
	logic [7:0]  map_q, map_d;
	logic [7:0]  rdata_d;
	logic [1:0]  p1_d, p2_d, cnt_d;
	hpsr_state_e st_q, st_d;
	logic [2:0]  swap_sel;
	logic [3:0]  p1_code, p2_code;

	// Reset release through two flops
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	// Register reset request handling
	always_comb begin
		st_d = st_q;
		case (st_q)
			HPSR_ST_IDLE:  if (reg_reset_req) st_d = HPSR_ST_CLEAR;
			HPSR_ST_CLEAR: st_d = HPSR_ST_DONE;
			HPSR_ST_DONE:  if (!reg_reset_req) st_d = HPSR_ST_IDLE;
			default:       st_d = HPSR_ST_IDLE;
		endcase
	end
	// Busy drops after clearing so the requester's bit returns to 0
	assign reg_reset_busy = (st_q == HPSR_ST_CLEAR);

	always_comb begin
		swap_d = swap_q;
		map_d  = map_q;
		if (st_q == HPSR_ST_CLEAR) begin
			swap_d = SWAP_RST;
			map_d  = MAP_RST;
		end else if (wr_en && addr == ADDR_SWAP) begin
			swap_d = wdata & SWAP_MASK;
		end else if (wr_en && addr == ADDR_MAP) begin
			map_d = wdata;
		end
	end

	always_comb begin
		case (addr)
			ADDR_SWAP: rdata_d = swap_q;
			ADDR_MAP:  rdata_d = map_q;
			default:   rdata_d = 8'h00;
		endcase
	end

	// Logical numbering; hub reports a fixed count unless remap is enabled, then the count of enabled ports
	always_comb begin
		p1_d  = LOG_ONE;
		p2_d  = LOG_TWO;
		cnt_d = PORT_COUNT;
		if (logical_remap_enable) begin
			p1_d = hpsr_decode(map_q[P1_LSB +: FIELD_W]);
			p2_d = hpsr_decode(map_q[P2_LSB +: FIELD_W]);
			cnt_d = {1'b0, p1_d != LOG_NONE} + {1'b0, p2_d != LOG_NONE};
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			swap_q        <= SWAP_RST;
			map_q         <= MAP_RST;
			st_q          <= HPSR_ST_IDLE;
			rdata         <= 8'h00;
			port1_logical <= LOG_ONE;
			port2_logical <= LOG_TWO;
			port_count    <= PORT_COUNT;
		end else if (clk_en) begin
			swap_q        <= swap_d;
			map_q         <= map_d;
			st_q          <= st_d;
			rdata         <= rdata_d;
			port1_logical <= p1_d;
			port2_logical <= p2_d;
			port_count    <= cnt_d;
		end
	end

	hpsr_pin_swap u_swap_up (
		.swap    (swap_q[SWAP_UP_BIT]),
		.dp_in   (dp_func[0]),
		.dm_in   (dm_func[0]),
		.pos_pin (pos_pin[0]),
		.neg_pin (neg_pin[0])
	);
	hpsr_pin_swap u_swap_p1 (
		.swap    (swap_q[SWAP_P1_BIT]),
		.dp_in   (dp_func[1]),
		.dm_in   (dm_func[1]),
		.pos_pin (pos_pin[1]),
		.neg_pin (neg_pin[1])
	);
	hpsr_pin_swap u_swap_p2 (
		.swap    (swap_q[SWAP_P2_BIT]),
		.dp_in   (dp_func[2]),
		.dm_in   (dm_func[2]),
		.pos_pin (pos_pin[2]),
		.neg_pin (neg_pin[2])
	);

	// Field views used by the checks
	assign swap_sel = swap_q[SWAP_P2_BIT:SWAP_UP_BIT];
	assign p1_code  = map_q[P1_LSB +: FIELD_W];
	assign p2_code  = map_q[P2_LSB +: FIELD_W];

	// Steps of a register reset request
	sequence s_reset_taken;
		clk_en && st_q == HPSR_ST_IDLE && reg_reset_req;
	endsequence
	sequence s_clear_cycle;
		clk_en && st_q == HPSR_ST_CLEAR;
	endsequence

	AST_RESERVED_SWAP: assert property (@(posedge clock)
		disable iff (!rst_n) (swap_q & ~SWAP_MASK) == 8'h00)
		else $error("reserved swap bits set");
	AST_SWAP_ROUTE: assert property (@(posedge clock)
		disable iff (!rst_n)
		pos_pin[1] == (swap_q[SWAP_P1_BIT] ? dm_func[1] : dp_func[1]))
		else $error("port 1 pin routing wrong");
	AST_PIN_STRAIGHT: assert property (@(posedge clock)
		disable iff (!rst_n)
		((pos_pin ^ dp_func) & ~swap_sel) == 3'h0
		&& ((neg_pin ^ dm_func) & ~swap_sel) == 3'h0)
		else $error("unswapped pin routing wrong");
	AST_PIN_CROSSED: assert property (@(posedge clock)
		disable iff (!rst_n)
		((pos_pin ^ dm_func) & swap_sel) == 3'h0
		&& ((neg_pin ^ dp_func) & swap_sel) == 3'h0)
		else $error("swapped pin routing wrong");
	AST_NO_REMAP: assert property (@(posedge clock)
		disable iff (!rst_n)
		clk_en && !logical_remap_enable |=> port1_logical == LOG_ONE)
		else $error("remap without enable");
	AST_NO_REMAP_P2: assert property (@(posedge clock)
		disable iff (!rst_n)
		clk_en && !logical_remap_enable |=> port2_logical == LOG_TWO)
		else $error("port 2 remap without enable");
	AST_P2_DECODE: assert property (@(posedge clock)
		disable iff (!rst_n)
		clk_en && logical_remap_enable && p2_code == CODE_LOG2
		|=> port2_logical == LOG_TWO)
		else $error("port 2 decode wrong");
	AST_P2_TO_ONE: assert property (@(posedge clock)
		disable iff (!rst_n)
		clk_en && logical_remap_enable && p2_code == CODE_LOG1
		|=> port2_logical == LOG_ONE)
		else $error("port 2 to logical 1 wrong");
	AST_P2_OFF: assert property (@(posedge clock)
		disable iff (!rst_n)
		clk_en && logical_remap_enable && p2_code == CODE_OFF
		|=> port2_logical == LOG_NONE)
		else $error("port 2 not disabled");
	AST_P1_DECODE: assert property (@(posedge clock)
		disable iff (!rst_n)
		clk_en && logical_remap_enable && p1_code == CODE_LOG1
		|=> port1_logical == LOG_ONE)
		else $error("port 1 decode wrong");
	AST_P1_TO_TWO: assert property (@(posedge clock)
		disable iff (!rst_n)
		clk_en && logical_remap_enable && p1_code == CODE_LOG2
		|=> port1_logical == LOG_TWO)
		else $error("port 1 to logical 2 wrong");
	AST_P1_OFF: assert property (@(posedge clock)
		disable iff (!rst_n)
		clk_en && logical_remap_enable && p1_code == CODE_OFF
		|=> port1_logical == LOG_NONE)
		else $error("port 1 not disabled");
	AST_RSVD_CODE: assert property (@(posedge clock)
		disable iff (!rst_n)
		clk_en && logical_remap_enable && p1_code > CODE_LOG2
		|=> port1_logical == LOG_NONE)
		else $error("reserved code not disabled");
	AST_RSVD_CODE_P2: assert property (@(posedge clock)
		disable iff (!rst_n)
		clk_en && logical_remap_enable && p2_code > CODE_LOG2
		|=> port2_logical == LOG_NONE)
		else $error("port 2 reserved code not disabled");
	AST_RESET_TAKEN: assert property (@(posedge clock)
		disable iff (!rst_n)
		s_reset_taken |=> reg_reset_busy)
		else $error("reset request not taken");
	AST_REG_RESET: assert property (@(posedge clock)
		disable iff (!rst_n)
		s_clear_cycle |=> swap_q == SWAP_RST
		&& map_q == MAP_RST && !reg_reset_busy)
		else $error("register reset failed");
	AST_RESET_FLOW: assert property (@(posedge clock)
		disable iff (!rst_n)
		s_reset_taken ##1 s_clear_cycle |=> st_q == HPSR_ST_DONE)
		else $error("reset request did not complete");
	AST_NO_REPEAT: assert property (@(posedge clock)
		disable iff (!rst_n)
		clk_en && st_q == HPSR_ST_DONE && reg_reset_req
		|=> !reg_reset_busy)
		else $error("held request cleared twice");
	AST_RESET_VALUES: assert property (@(posedge clock)
		$rose(rst_n) |-> swap_q == SWAP_RST && map_q == MAP_RST)
		else $error("registers not at reset value");
	AST_COUNT_FIXED: assert property (@(posedge clock)
		disable iff (!rst_n)
		clk_en && !logical_remap_enable |=> port_count == PORT_COUNT)
		else $error("port count wrong");
	AST_COUNT_NONE: assert property (@(posedge clock)
		disable iff (!rst_n)
		clk_en && logical_remap_enable && p1_code == CODE_OFF
		&& p2_code == CODE_OFF |=> port_count == 2'h0)
		else $error("count with no enabled port wrong");
	AST_CLK_HOLD: assert property (@(posedge clock)
		disable iff (!rst_n)
		!clk_en |=> $stable(swap_q) && $stable(map_q)
		&& $stable(st_q) && $stable(rdata))
		else $error("state moved while clock enable low");
endmodule : hpsr_top

// ---- hpsr_pkg.sv ----
package hpsr_pkg;
	localparam int unsigned ADDR_W      = 8;
	localparam int unsigned DATA_W      = 8;
	localparam logic [7:0]  ADDR_SWAP   = 8'hFA;
	localparam logic [7:0]  ADDR_MAP    = 8'hFB;
	localparam logic [7:0]  SWAP_RST    = 8'h00;
	localparam logic [7:0]  MAP_RST     = 8'h00;
	localparam int unsigned SWAP_UP_BIT = 0;
	localparam int unsigned SWAP_P1_BIT = 1;
	localparam int unsigned SWAP_P2_BIT = 2;
	localparam logic [7:0]  SWAP_MASK   = 8'h07;
	localparam int unsigned P1_LSB      = 0;
	localparam int unsigned P2_LSB      = 4;
	localparam int unsigned FIELD_W     = 4;
	localparam logic [3:0]  CODE_OFF    = 4'h0;
	localparam logic [3:0]  CODE_LOG1   = 4'h1;
	localparam logic [3:0]  CODE_LOG2   = 4'h2;
	localparam logic [1:0]  LOG_NONE    = 2'h0;
	localparam logic [1:0]  LOG_ONE     = 2'h1;
	localparam logic [1:0]  LOG_TWO     = 2'h2;
	localparam logic [1:0]  PORT_COUNT  = 2'h2;

	typedef enum logic [1:0] {
		HPSR_ST_IDLE  = 2'b00,
		HPSR_ST_CLEAR = 2'b01,
		HPSR_ST_DONE  = 2'b10
	} hpsr_state_e;

	function automatic logic [1:0] hpsr_decode(input logic [3:0] code);
		case (code)
			CODE_LOG1: hpsr_decode = LOG_ONE;
			CODE_LOG2: hpsr_decode = LOG_TWO;
			default:   hpsr_decode = LOG_NONE;
		endcase
	endfunction : hpsr_decode
endpackage : hpsr_pkg

// ---- hpsr_pin_swap.sv ----
`timescale 1ns/1ns
module hpsr_pin_swap (
	input  wire logic swap,
	input  wire logic dp_in,
	input  wire logic dm_in,
	output logic      pos_pin,
	output logic      neg_pin
);
	// D+ goes to negative pin when swapped
	assign pos_pin = swap ? dm_in : dp_in;
	assign neg_pin = swap ? dp_in : dm_in;
endmodule : hpsr_pin_swap

// ---- hpsr_host_model.sv ----
`timescale 1ns/1ns
module hpsr_host_model (
	input  wire logic [1:0] port_count,
	output logic      [1:0] first_num,
	output logic      [1:0] last_num
);
	// Host numbers downstream ports from one up to the reported count
	assign first_num = (port_count != 2'h0) ? 2'h1 : 2'h0;
	assign last_num  = port_count;
endmodule : hpsr_host_model

// ---- hpsr_top_tb.sv ----
`timescale 1ns/1ns
module hpsr_top_tb;
	import hpsr_pkg::*;
	logic       clock, nrst, wr_en, req, busy, en, ce;
	logic [7:0] addr, wdata, rdata;
	logic [2:0] dp, dm, pos, neg;
	logic [1:0] l1, l2, cnt, hf, hl;
	int         fail_count = 0;
	int         num_checks = 0;
	hpsr_top hpsr_top_i (.clock(clock), .nrst(nrst), .clk_en(ce),
		.wr_en(wr_en), .addr(addr), .wdata(wdata), .rdata(rdata),
		.reg_reset_req(req), .reg_reset_busy(busy),
		.logical_remap_enable(en), .dp_func(dp), .dm_func(dm),
		.pos_pin(pos), .neg_pin(neg), .port1_logical(l1),
		.port2_logical(l2), .port_count(cnt));
	hpsr_host_model hpsr_host_model_i (.port_count(cnt),
		.first_num(hf), .last_num(hl));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic close_out;
		$display("checks=%0d errors=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : close_out
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clock);
		wr_en = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		addr = a;
		@(negedge clock);
		chk(rdata, e);
	endtask : rd
	function automatic logic [1:0] dec(input logic [3:0] c);
		return (c == 4'h1 || c == 4'h2) ? c[1:0] : 2'h0;
	endfunction : dec
	task automatic remap(input logic [7:0] m);
		logic [1:0] a, b;
		a = en ? dec(m[3:0]) : 2'h1;
		b = en ? dec(m[7:4]) : 2'h2;
		wr(ADDR_MAP, m);
		@(negedge clock);
		chk(8'(l1), 8'(a));
		chk(8'(l2), 8'(b));
		chk(8'(cnt), en ? 8'(a != 2'h0) + 8'(b != 2'h0) : 8'h2);
	endtask : remap
	initial begin
		#20000;
		fail_count++;
		close_out();
	end
	initial begin
		int k;
		nrst = 1'b0;
		{wr_en, req, en} = 3'h0;
		ce = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		dp = 3'h5;
		dm = 3'h2;
		repeat (5) @(negedge clock);
		nrst = 1'b1;
		repeat (3) @(negedge clock);
		rd(ADDR_SWAP, SWAP_RST);
		rd(ADDR_MAP, MAP_RST);
		rd(8'hF9, 8'h00);
		chk(8'(cnt), 8'h2);
		ce = 1'b0;
		wr(ADDR_SWAP, 8'h07);
		chk(8'(pos), 8'(dp));
		ce = 1'b1;
		rd(ADDR_SWAP, SWAP_RST);
		for (int s = 0; s < 8; s++) begin
			wr(ADDR_SWAP, 8'(s) | 8'hF8);
			rd(ADDR_SWAP, 8'(s));
			chk(8'(pos), 8'((dp & ~s[2:0]) | (dm & s[2:0])));
			chk(8'(neg), 8'((dm & ~s[2:0]) | (dp & s[2:0])));
		end
		remap(8'h21);
		en = 1'b1;
		for (int i = 0; i < 16; i++) remap({i[3:0], 4'(15 - i)});
		remap(8'h12);
		chk(8'(hf), 8'h1);
		chk(8'(hl), 8'h2);
		req = 1'b1;
		for (k = 0; k < 4 && busy !== 1'b1; k++) @(negedge clock);
		chk(8'(busy), 8'h1);
		@(negedge clock);
		chk(8'(busy), 8'h0);
		@(negedge clock);
		chk(8'(busy), 8'h0);
		req = 1'b0;
		@(negedge clock);
		rd(ADDR_SWAP, SWAP_RST);
		rd(ADDR_MAP, MAP_RST);
		chk(8'(l1), 8'h0);
		wr(ADDR_SWAP, 8'h05);
		rd(ADDR_SWAP, 8'h05);
		wr(ADDR_MAP, 8'h21);
		nrst = 1'b0;
		repeat (2) @(negedge clock);
		chk(8'(pos), 8'(dp));
		nrst = 1'b1;
		repeat (3) @(negedge clock);
		rd(ADDR_MAP, MAP_RST);
		chk(8'(l2), 8'h0);
		close_out();
	end
endmodule : hpsr_top_tb
